// *** hdl/gtfm_defines.svh ***
`ifndef GTFM_DEFINES_SVH
`define GTFM_DEFINES_SVH

// ==========================================================
// Register offsets
`define GTFM_TEST_CTRL_OFS      9'h03d
`define GTFM_CLK_SYNC_MON_OFS   9'h03e
`define GTFM_BUS_ERR_MON_OFS    9'h03f

// ==========================================================
// Test control fields
`define GTFM_LEAK_BYPASS_BIT    4
`define GTFM_PRBS_CLK_SEL_BIT   3
`define GTFM_TM_DISABLE_BIT     2
`define GTFM_STUFF_PHASE_MSB    1
`define GTFM_STUFF_PHASE_LSB    0

// ==========================================================
// Clock and sync monitor fields
`define GTFM_RX_CLK_FM_BIT      7
`define GTFM_RX_SYNC_FM_BIT     6
`define GTFM_RX_PAY_FM_BIT      5
`define GTFM_MCLK_FM_BIT        3
`define GTFM_TX_CLK_FM_BIT      2
`define GTFM_TX_SYNC_FM_BIT     1
`define GTFM_TX_PAY_FM_BIT      0

// ==========================================================
// Bus error monitor fields
`define GTFM_RX_PAR_FM_BIT      3
`define GTFM_PRBS_FM_BIT        2
`define GTFM_INT_COLL_FM_BIT    1
`define GTFM_EXT_COLL_FM_BIT    0

// ==========================================================
// Writable masks and reset values
`define GTFM_TEST_CTRL_MASK     8'h1f
`define GTFM_TEST_CTRL_RST      8'h00
`define GTFM_MON_RST            11'h000
`define GTFM_RDATA_RST          8'h00

// ==========================================================
// Monitor count and split between the two registers
`define GTFM_NUM_MON            11
`define GTFM_NUM_MON_FIRST      7

`endif

// *** hdl/gtfm_pkg.sv ***
package gtfm_pkg;
   // Register data byte
   typedef logic [7:0] gtfm_byte_t;
   // One bit per monitored condition, ordered as in the two monitor registers
   typedef logic [10:0] gtfm_mon_vec_t;
   // Which register an address selects
   typedef enum logic [1:0] {
      GTFM_SEL_NONE,
      GTFM_SEL_TEST,
      GTFM_SEL_CLK_SYNC,
      GTFM_SEL_BUS_ERR
   } gtfm_sel_t;
endpackage

// *** hdl/gtfm_top.sv ***
// How it works
// - Bypass bit one skips leak buffer everywhere
// - PRBS clock select zero uses master clock
// - Disable bit one turns threshold modulator off
// - Nonzero stuff phase field picks alternate phase
// - Monitor sets for condition older than interval
// - Write zero, or tick edge with condition and event both low, clears monitor
// - First register bit 7: drop clock loss
// - First register bit 6: drop sync loss
// - First register bit 5: drop payload loss
// - First register bit 3: master clock loss
// - First register bit 2: add clock loss
// - First register bit 1: add sync loss
// - First register bit 0: add payload loss
// - Second register bit 3: receive parity error
// - Second register bit 2: PRBS out of lock
// - Second register bit 1: internal bus collision
// - Second register bit 0: external bus collision
`timescale 1ns/1ns
`default_nettype none
`include "gtfm_defines.svh"

module gtfm_top
   import gtfm_pkg::*;
#(
   parameter int ADDR_W = 9
) (
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire logic              clk_en,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr_en,
   input  wire logic              reg_rd_en,
   output var  logic [7:0]        reg_rdata,
   output var  logic              reg_rdata_valid,
   input  wire logic              one_second_tick,
   input  wire logic              drop_clock_loss,
   input  wire logic              drop_sync_loss,
   input  wire logic              drop_payload_loss,
   input  wire logic              master_clock_loss,
   input  wire logic              add_clock_loss,
   input  wire logic              add_sync_loss,
   input  wire logic              add_payload_loss,
   input  wire logic              rx_parity_error,
   input  wire logic              pattern_out_of_lock,
   input  wire logic              internal_collision,
   input  wire logic              external_collision,
   input  wire logic              drop_clock_event,
   input  wire logic              drop_sync_event,
   input  wire logic              drop_payload_event,
   input  wire logic              master_clock_event,
   input  wire logic              add_clock_event,
   input  wire logic              add_sync_event,
   input  wire logic              add_payload_event,
   input  wire logic              receive_parity_event,
   input  wire logic              pattern_lock_event,
   input  wire logic              internal_collision_event,
   input  wire logic              external_collision_event,
   output var  logic              leak_buffer_bypass,
   output var  logic              leak_buffer_enable,
   output var  logic              prbs_clock_select,
   output var  logic              prbs_use_master_clock,
   output var  logic              threshold_modulator_disable,
   output var  logic              threshold_modulator_enable,
   output var  logic [1:0]        stuff_phase_select,
   output var  logic              stuff_phase_alternate,
   output var  logic              rx_clock_fault_monitor,
   output var  logic              rx_sync_fault_monitor,
   output var  logic              rx_payload_fault_monitor,
   output var  logic              master_clock_fault_monitor,
   output var  logic              tx_clock_fault_monitor,
   output var  logic              tx_sync_fault_monitor,
   output var  logic              tx_payload_fault_monitor,
   output var  logic              rx_parity_fault_monitor,
   output var  logic              pattern_lock_fault_monitor,
   output var  logic              internal_collision_fault_monitor,
   output var  logic              external_collision_fault_monitor
);

   // ==========================================================
   // Elaboration check
   // The highest offset needs six address bits
   if (ADDR_W < 6) begin : g_addr_chk
      $error("gtfm_top: ADDR_W must be at least 6");
   end

   // The vector type, the monitor count and the register split must agree,
   // since the pack functions and the generate loop rely on all three
   if ($bits(gtfm_mon_vec_t) != `GTFM_NUM_MON) begin : g_mon_chk
      $error("gtfm_top: monitor vector width and count differ");
   end
   if (`GTFM_NUM_MON - `GTFM_NUM_MON_FIRST != 4) begin : g_split_chk
      $error("gtfm_top: second monitor register must hold four bits");
   end

   // ==========================================================
   // Address decode
   // Used by both the write and the read path
   // Any other address is ignored on write and reads as zero
   function automatic gtfm_sel_t decode_addr(input logic [ADDR_W-1:0] a);
      gtfm_sel_t s;
      s = GTFM_SEL_NONE;
      if (a == ADDR_W'(`GTFM_TEST_CTRL_OFS)) begin
         s = GTFM_SEL_TEST;
      end else if (a == ADDR_W'(`GTFM_CLK_SYNC_MON_OFS)) begin
         s = GTFM_SEL_CLK_SYNC;
      end else if (a == ADDR_W'(`GTFM_BUS_ERR_MON_OFS)) begin
         s = GTFM_SEL_BUS_ERR;
      end
      return s;
   endfunction

   // Place the monitor vector into the two register layouts
   // Reserved positions stay zero, so software always reads zeros there
   function automatic gtfm_byte_t pack_first(input gtfm_mon_vec_t m);
      gtfm_byte_t b;
      b = 8'h00;
      b[`GTFM_RX_CLK_FM_BIT]  = m[0];
      b[`GTFM_RX_SYNC_FM_BIT] = m[1];
      b[`GTFM_RX_PAY_FM_BIT]  = m[2];
      b[`GTFM_MCLK_FM_BIT]    = m[3];
      b[`GTFM_TX_CLK_FM_BIT]  = m[4];
      b[`GTFM_TX_SYNC_FM_BIT] = m[5];
      b[`GTFM_TX_PAY_FM_BIT]  = m[6];
      return b;
   endfunction

   function automatic gtfm_byte_t pack_second(input gtfm_mon_vec_t m);
      gtfm_byte_t b;
      b = 8'h00;
      b[`GTFM_RX_PAR_FM_BIT]   = m[7];
      b[`GTFM_PRBS_FM_BIT]     = m[8];
      b[`GTFM_INT_COLL_FM_BIT] = m[9];
      b[`GTFM_EXT_COLL_FM_BIT] = m[10];
      return b;
   endfunction

   gtfm_sel_t sel;
   assign sel = decode_addr(reg_addr);

   // ==========================================================
   // Test control register
   gtfm_byte_t test_ctrl_ff;

   // Reserved bits are masked off, so they always read as zero
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         test_ctrl_ff <= `GTFM_TEST_CTRL_RST;
      end else if (clk_en && reg_wr_en && sel == GTFM_SEL_TEST) begin
         test_ctrl_ff <= reg_wdata & `GTFM_TEST_CTRL_MASK;
      end
   end

   // Control outputs straight from the register
   assign leak_buffer_bypass          = test_ctrl_ff[`GTFM_LEAK_BYPASS_BIT];
   assign leak_buffer_enable          = ~leak_buffer_bypass;
   assign prbs_clock_select           = test_ctrl_ff[`GTFM_PRBS_CLK_SEL_BIT];
   // Setting one is a factory mode only; nothing here guards it
   assign prbs_use_master_clock       = ~prbs_clock_select;
   assign threshold_modulator_disable = test_ctrl_ff[`GTFM_TM_DISABLE_BIT];
   assign threshold_modulator_enable  = ~threshold_modulator_disable;
   assign stuff_phase_select          =
      test_ctrl_ff[`GTFM_STUFF_PHASE_MSB:`GTFM_STUFF_PHASE_LSB];
   assign stuff_phase_alternate       = |stuff_phase_select;

   // ==========================================================
   // One-second tick synchroniser and edge detect
   // The tick arrives from a pin, so it passes two flops first
   // Only the second flop feeds logic; a tick high for less than one
   // clock period may be missed, so the pin must stay high longer
   logic tick_meta_ff;
   logic tick_sync_ff;
   logic tick_last_ff;
   logic tick_rise;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         tick_meta_ff <= 1'b0;
         tick_sync_ff <= 1'b0;
         tick_last_ff <= 1'b0;
      end else if (clk_en) begin
         tick_meta_ff <= one_second_tick;
         tick_sync_ff <= tick_meta_ff;
         tick_last_ff <= tick_sync_ff;
      end
   end

   assign tick_rise = tick_sync_ff & ~tick_last_ff;

   // ==========================================================
   // Condition and companion event vectors
   gtfm_mon_vec_t cond;
   gtfm_mon_vec_t evt;

   assign cond = {external_collision,
                  internal_collision,
                  pattern_out_of_lock,
                  rx_parity_error,
                  add_payload_loss,
                  add_sync_loss,
                  add_clock_loss,
                  master_clock_loss,
                  drop_payload_loss,
                  drop_sync_loss,
                  drop_clock_loss};

   assign evt  = {external_collision_event,
                  internal_collision_event,
                  pattern_lock_event,
                  receive_parity_event,
                  add_payload_event,
                  add_sync_event,
                  add_clock_event,
                  master_clock_event,
                  drop_payload_event,
                  drop_sync_event,
                  drop_clock_event};

   // Software write that hits a monitor bit with zero
   // Writing one to a monitor bit leaves it alone; only zeros clear
   gtfm_mon_vec_t sw_clr;
   gtfm_byte_t    first_zero;
   gtfm_byte_t    second_zero;

   assign first_zero  = (reg_wr_en && sel == GTFM_SEL_CLK_SYNC) ?
                        ~reg_wdata : 8'h00;
   assign second_zero = (reg_wr_en && sel == GTFM_SEL_BUS_ERR) ?
                        ~reg_wdata : 8'h00;

   assign sw_clr = {second_zero[`GTFM_EXT_COLL_FM_BIT],
                    second_zero[`GTFM_INT_COLL_FM_BIT],
                    second_zero[`GTFM_PRBS_FM_BIT],
                    second_zero[`GTFM_RX_PAR_FM_BIT],
                    first_zero[`GTFM_TX_PAY_FM_BIT],
                    first_zero[`GTFM_TX_SYNC_FM_BIT],
                    first_zero[`GTFM_TX_CLK_FM_BIT],
                    first_zero[`GTFM_MCLK_FM_BIT],
                    first_zero[`GTFM_RX_PAY_FM_BIT],
                    first_zero[`GTFM_RX_SYNC_FM_BIT],
                    first_zero[`GTFM_RX_CLK_FM_BIT]};

   // ==========================================================
   // Per-condition onset tracking and monitor bits
   // A software clear loses to a fault that has outlived a whole interval:
   // the bit stays set, so a write never hides such a fault. Events are
   // taken as levels; the event logic itself lives outside this block.
   gtfm_mon_vec_t cond_last_ff;
   gtfm_mon_vec_t onset_cur_ff;
   gtfm_mon_vec_t onset_prev_ff;
   gtfm_mon_vec_t mon_ff;

   for (genvar i = 0; i < `GTFM_NUM_MON; i++) begin : g_mon
      logic onset;
      logic mon_set;
      logic mon_clr;

      // A condition present at reset release counts as a fresh onset
      assign onset = cond[i] & ~cond_last_ff[i];

      // Onset seen in the interval now running, or the one just ended
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            cond_last_ff[i]  <= 1'b0;
            onset_cur_ff[i]  <= 1'b0;
            onset_prev_ff[i] <= 1'b0;
         end else if (clk_en) begin
            cond_last_ff[i] <= cond[i];
            if (tick_rise) begin
               // An onset on the tick edge belongs to the new interval
               onset_cur_ff[i]  <= onset;
               onset_prev_ff[i] <= onset_cur_ff[i];
            end else if (onset) begin
               onset_cur_ff[i] <= 1'b1;
            end
         end
      end

      // Set only once the condition has outlived a whole interval
      assign mon_set = cond[i] & ~onset & ~onset_cur_ff[i]
                       & ~onset_prev_ff[i];
      assign mon_clr = sw_clr[i]
                       | (tick_rise & ~cond[i] & ~evt[i]);

      // Set wins over a clear in the same cycle
      always_ff @(posedge ref_clk or posedge rst) begin
         if (rst) begin
            mon_ff[i] <= 1'b0;
         end else if (clk_en) begin
            mon_ff[i] <= mon_set | (mon_ff[i] & ~mon_clr);
         end
      end
   end

   // ==========================================================
   // Monitor outputs
   assign rx_clock_fault_monitor           = mon_ff[0];
   assign rx_sync_fault_monitor            = mon_ff[1];
   assign rx_payload_fault_monitor         = mon_ff[2];
   assign master_clock_fault_monitor       = mon_ff[3];
   assign tx_clock_fault_monitor           = mon_ff[4];
   assign tx_sync_fault_monitor            = mon_ff[5];
   assign tx_payload_fault_monitor         = mon_ff[6];
   assign rx_parity_fault_monitor          = mon_ff[7];
   assign pattern_lock_fault_monitor       = mon_ff[8];
   assign internal_collision_fault_monitor = mon_ff[9];
   assign external_collision_fault_monitor = mon_ff[10];

   // ==========================================================
   // Read path
   // Registered so read data is stable a full cycle after the strobe
   // A read in the same cycle as a write returns the old contents
   gtfm_byte_t nxt_rdata;
   gtfm_byte_t rdata_ff;
   logic       rvalid_ff;

   always_comb begin
      case (sel)
         GTFM_SEL_TEST:     nxt_rdata = test_ctrl_ff;
         GTFM_SEL_CLK_SYNC: nxt_rdata = pack_first(mon_ff);
         GTFM_SEL_BUS_ERR:  nxt_rdata = pack_second(mon_ff);
         default:           nxt_rdata = 8'h00; // Unmapped reads zero
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata_ff  <= `GTFM_RDATA_RST;
         rvalid_ff <= 1'b0;
      end else if (clk_en) begin
         rvalid_ff <= reg_rd_en;
         if (reg_rd_en) begin
            rdata_ff <= nxt_rdata;
         end
      end
   end

   assign reg_rdata       = rdata_ff;
   assign reg_rdata_valid = rvalid_ff;

endmodule // gtfm_top

`default_nettype wire

// *** sim/gtfm_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "gtfm_defines.svh"
// ==========================================================
// Checker on the top module ports
module gtfm_checker
   import gtfm_pkg::*;
#(
   parameter int ADDR_W = 9
) (
   input wire logic              ref_clk,
   input wire logic              rst,
   input wire logic              clk_en,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [7:0]        reg_wdata,
   input wire logic              reg_wr_en,
   input wire logic              reg_rd_en,
   input wire logic [7:0]        reg_rdata,
   input wire logic              reg_rdata_valid,
   input wire logic              drop_clock_loss,
   input wire logic              rx_parity_error,
   input wire logic              pattern_out_of_lock,
   input wire logic              pattern_lock_event,
   input wire logic              leak_buffer_bypass,
   input wire logic              leak_buffer_enable,
   input wire logic              prbs_clock_select,
   input wire logic              prbs_use_master_clock,
   input wire logic              threshold_modulator_disable,
   input wire logic              threshold_modulator_enable,
   input wire logic [1:0]        stuff_phase_select,
   input wire logic              stuff_phase_alternate,
   input wire logic              rx_clock_fault_monitor,
   input wire logic              rx_parity_fault_monitor,
   input wire logic              pattern_lock_fault_monitor
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   // Decoded controls must agree with the register bits
   property p_leak;
      leak_buffer_enable == !leak_buffer_bypass;
   endproperty
   a_leak: assert property (p_leak) else $error("leak enable wrong");
   property p_prbs;
      prbs_use_master_clock == !prbs_clock_select;
   endproperty
   a_prbs: assert property (p_prbs) else $error("prbs clock wrong");
   property p_tmod;
      threshold_modulator_enable == !threshold_modulator_disable;
   endproperty
   a_tmod: assert property (p_tmod) else $error("modulator wrong");
   property p_phase;
      stuff_phase_alternate == (stuff_phase_select != 2'b00);
   endproperty
   a_phase: assert property (p_phase) else $error("phase wrong");

   // Writes land one edge later, reads echo with zeros in reserved bits
   property p_wr;
      clk_en && reg_wr_en && reg_addr == `GTFM_TEST_CTRL_OFS |=>
      {leak_buffer_bypass, prbs_clock_select, threshold_modulator_disable,
       stuff_phase_select} == $past(reg_wdata[4:0]);
   endproperty
   a_wr: assert property (p_wr) else $error("control write lost");
   property p_rd;
      clk_en && reg_rd_en && !reg_wr_en && reg_addr == `GTFM_TEST_CTRL_OFS
      |=> reg_rdata == {3'b000, leak_buffer_bypass, prbs_clock_select,
                        threshold_modulator_disable, stuff_phase_select};
   endproperty
   a_rd: assert property (p_rd) else $error("control read wrong");
   property p_unm;
      clk_en && reg_rd_en && !(reg_addr inside {`GTFM_TEST_CTRL_OFS,
      `GTFM_CLK_SYNC_MON_OFS, `GTFM_BUS_ERR_MON_OFS}) |=> reg_rdata == 8'h00;
   endproperty
   a_unm: assert property (p_unm) else $error("unmapped read nonzero");
   // Valid is a single pulse when no read follows
   property p_vld;
      clk_en && reg_rd_en ##1 (clk_en && !reg_rd_en) |->
      reg_rdata_valid ##1 !reg_rdata_valid;
   endproperty
   a_vld: assert property (p_vld) else $error("valid pulse wrong");

   // Monitor bits move only for their documented causes
   property p_clr;
      clk_en && reg_wr_en && reg_addr == `GTFM_CLK_SYNC_MON_OFS &&
      !reg_wdata[7] && !drop_clock_loss && !$past(drop_clock_loss)
      |=> !rx_clock_fault_monitor;
   endproperty
   a_clr: assert property (p_clr) else $error("monitor kept");
   property p_rise;
      $rose(rx_parity_fault_monitor) |-> $past(rx_parity_error);
   endproperty
   a_rise: assert property (p_rise) else $error("unfounded set");
   property p_fall;
      $fell(pattern_lock_fault_monitor) && !$past(reg_wr_en) |->
      !$past(pattern_out_of_lock) && !$past(pattern_lock_event);
   endproperty
   a_fall: assert property (p_fall) else $error("early clear");
endmodule // gtfm_checker

bind gtfm_top gtfm_checker #(.ADDR_W(ADDR_W)) i_gtfm_checker (
   .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
   .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
   .drop_clock_loss(drop_clock_loss), .rx_parity_error(rx_parity_error),
   .pattern_out_of_lock(pattern_out_of_lock),
   .pattern_lock_event(pattern_lock_event),
   .leak_buffer_bypass(leak_buffer_bypass),
   .leak_buffer_enable(leak_buffer_enable),
   .prbs_clock_select(prbs_clock_select),
   .prbs_use_master_clock(prbs_use_master_clock),
   .threshold_modulator_disable(threshold_modulator_disable),
   .threshold_modulator_enable(threshold_modulator_enable),
   .stuff_phase_select(stuff_phase_select),
   .stuff_phase_alternate(stuff_phase_alternate),
   .rx_clock_fault_monitor(rx_clock_fault_monitor),
   .rx_parity_fault_monitor(rx_parity_fault_monitor),
   .pattern_lock_fault_monitor(pattern_lock_fault_monitor));
`default_nettype wire

// *** sim/gtfm_top_test.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "gtfm_defines.svh"
// ==========================================================
// Bench: register calls with expected values
module gtfm_top_test;
   import gtfm_pkg::*;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        clk_en = 1'b1;
   logic [8:0]  reg_addr = 9'h000;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr_en = 1'b0;
   logic        reg_rd_en = 1'b0;
   logic        tick = 1'b0;
   logic [10:0] cond = 11'h000;
   logic [10:0] ev = 11'h000;
   logic [10:0] pat;
   wire  [7:0]  reg_rdata;
   wire         reg_rdata_valid;
   wire  [10:0] mon;
   wire  [8:0]  dec;
   int          n_fail = 0;
   int          num_checks = 0;

   initial forever #20 ref_clk = ~ref_clk;

   gtfm_top i_gtfm_top (
      .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
      .one_second_tick(tick), .drop_clock_loss(cond[10]),
      .drop_sync_loss(cond[9]), .drop_payload_loss(cond[8]),
      .master_clock_loss(cond[7]), .add_clock_loss(cond[6]),
      .add_sync_loss(cond[5]), .add_payload_loss(cond[4]),
      .rx_parity_error(cond[3]), .pattern_out_of_lock(cond[2]),
      .internal_collision(cond[1]), .external_collision(cond[0]),
      .drop_clock_event(ev[10]), .drop_sync_event(ev[9]),
      .drop_payload_event(ev[8]), .master_clock_event(ev[7]),
      .add_clock_event(ev[6]), .add_sync_event(ev[5]),
      .add_payload_event(ev[4]), .receive_parity_event(ev[3]),
      .pattern_lock_event(ev[2]), .internal_collision_event(ev[1]),
      .external_collision_event(ev[0]),
      .leak_buffer_bypass(dec[8]), .leak_buffer_enable(dec[7]),
      .prbs_clock_select(dec[6]), .prbs_use_master_clock(dec[5]),
      .threshold_modulator_disable(dec[4]),
      .threshold_modulator_enable(dec[3]),
      .stuff_phase_select(dec[2:1]), .stuff_phase_alternate(dec[0]),
      .rx_clock_fault_monitor(mon[10]), .rx_sync_fault_monitor(mon[9]),
      .rx_payload_fault_monitor(mon[8]),
      .master_clock_fault_monitor(mon[7]), .tx_clock_fault_monitor(mon[6]),
      .tx_sync_fault_monitor(mon[5]), .tx_payload_fault_monitor(mon[4]),
      .rx_parity_fault_monitor(mon[3]), .pattern_lock_fault_monitor(mon[2]),
      .internal_collision_fault_monitor(mon[1]),
      .external_collision_fault_monitor(mon[0]));

   // ==========================================================
   // Shared tasks; inputs move on the falling edge only
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr_en = 1'b1;
      @(negedge ref_clk);
      reg_wr_en = 1'b0;
   endtask
   // Valid and data are looked at in the one cycle they stand
   task automatic rd(input logic [8:0] a, input logic [7:0] e);
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd_en = 1'b1;
      @(negedge ref_clk);
      reg_rd_en = 1'b0;
      chk({2'b00, reg_rdata_valid, reg_rdata}, {3'b001, e});
   endtask
   // Tick long enough to clear the pin synchroniser and edge detect
   task automatic tk;
      @(negedge ref_clk);
      tick = 1'b1;
      repeat (6) @(negedge ref_clk);
      tick = 1'b0;
      repeat (6) @(negedge ref_clk);
   endtask
   function automatic logic [10:0] dx(input logic [4:0] v);
      return {2'b00, v[4], !v[4], v[3], !v[3], v[2], !v[2], v[1:0], |v[1:0]};
   endfunction
   task automatic summarize;
      $display("Checks %0d, errors %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      repeat (12) @(negedge ref_clk);
      rst = 1'b0;
      chk({2'b00, dec}, 11'h0a8);
      rd(`GTFM_CLK_SYNC_MON_OFS, 8'h00);
      rd(`GTFM_BUS_ERR_MON_OFS, 8'h00);
      // Every control pattern, manufacturing and reserved bits kept at zero
      for (int i = 0; i < 32; i++) begin
         wr(`GTFM_TEST_CTRL_OFS, 8'(i) & 8'h17);
         chk({2'b00, dec}, dx(5'(i) & 5'h17));
         rd(`GTFM_TEST_CTRL_OFS, 8'(i) & 8'h17);
      end
      // Frozen clock enable drops the write
      clk_en = 1'b0;
      wr(`GTFM_TEST_CTRL_OFS, 8'h00);
      clk_en = 1'b1;
      rd(`GTFM_TEST_CTRL_OFS, 8'h17);
      wr(9'h03c, 8'hff);
      rd(9'h03c, 8'h00);
      wr(`GTFM_TEST_CTRL_OFS, 8'h00);
      // Two complementary patterns cover every monitor bit both ways
      for (int k = 0; k < 2; k++) begin
         pat = k ? 11'h256 : 11'h5a9;
         tk();
         cond = pat;
         ev = pat;
         tk();
         chk(mon, 11'h000);
         tk();
         chk(mon, pat);
         rd(`GTFM_CLK_SYNC_MON_OFS, {pat[10:8], 1'b0, pat[7:4]});
         rd(`GTFM_BUS_ERR_MON_OFS, {4'h0, pat[3:0]});
         cond = 11'h000;
         tk();
         chk(mon, pat);
         ev = 11'h000;
         wr(`GTFM_CLK_SYNC_MON_OFS, 8'h00);
         chk(mon, pat & 11'h00f);
         tk();
         chk(mon, 11'h000);
      end
      // Writing ones never sets a monitor; reserved bits stay zero
      wr(`GTFM_CLK_SYNC_MON_OFS, 8'hef);
      wr(`GTFM_BUS_ERR_MON_OFS, 8'h0f);
      chk(mon, 11'h000);
      summarize();
   end

   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      #200000;
      n_fail++;
      summarize();
   end
endmodule // gtfm_top_test
`default_nettype wire
